// file: rtl/rpbc_defines.svh
`ifndef RPBC_DEFINES_SVH
`define RPBC_DEFINES_SVH

// ----------------------------------------------------------------
// Per-port register map
// ----------------------------------------------------------------
`define RPBC_NUM_PORTS        4
`define RPBC_OFS_BCC          8'h58
`define RPBC_OFS_DPC1         8'h59
`define RPBC_OFS_DPC2         8'h5A

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define RPBC_BIT_PASS_ALL     7
`define RPBC_BIT_PASS_MATCH   6
`define RPBC_BIT_AUTO_ACK     5
`define RPBC_BIT_FORCE_ON     4
`define RPBC_BIT_CRC_EN       3
`define RPBC_BIT_KEEP_LOCAL   7

// ----------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------
`define RPBC_BCC_RST          8'h18
`define RPBC_DPC1_RST         8'h00
`define RPBC_DPC2_RST         8'h00
`define RPBC_RATE_2M5         3'h0
`define RPBC_RATE_10M         3'h2

`endif

// file: rtl/rpbc_pkg.sv
`default_nettype none
package rpbc_pkg;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic       pass_all;
      logic       pass_match;
      logic       auto_ack;
      logic       force_on;
      logic       crc_en;
      logic [2:0] rate;
   } rpbc_bcc_type;

   typedef struct packed {
      rpbc_bcc_type bcc;
      logic         keep_local;
      logic [1:0]   gpio_count;
      logic         strap_done;
      logic         rate_changed;
   } rpbc_port_state_type;

   typedef struct packed {
      logic [7:0]  rdata;
      logic [3:0]  forward;
      logic [3:0]  auto_ack;
      logic [3:0]  bc_enable;
      logic [3:0]  crc_en;
      logic [11:0] rate;
      logic [3:0]  unsettled;
      logic [15:0] gpio_en;
      logic [3:0]  keep_local;
   } rpbc_top_state_type;

   // ----------------------------------------------------------------
   // Shared decoding
   // ----------------------------------------------------------------
   function automatic logic [3:0] rpbc_gpio_mask(input logic [1:0] count);
      case (count)
         2'h0:    rpbc_gpio_mask = 4'h0;
         2'h1:    rpbc_gpio_mask = 4'h1;
         2'h2:    rpbc_gpio_mask = 4'h3;
         default: rpbc_gpio_mask = 4'hF;
      endcase
   endfunction : rpbc_gpio_mask

   function automatic logic rpbc_bc_on(input rpbc_bcc_type b);
      rpbc_bc_on = b.force_on | b.pass_all | b.pass_match;
   endfunction : rpbc_bc_on

endpackage : rpbc_pkg
`default_nettype wire

// file: rtl/rpbc_port_if.sv
`default_nettype none
interface rpbc_port_if;
   import rpbc_pkg::*;
   logic         wr_en;
   logic         wr_local;
   logic [7:0]   addr;
   logic [7:0]   wdata;
   logic [2:0]   strap_rate;
   logic         fc_valid;
   logic [1:0]   fc_gpio;
   rpbc_bcc_type bcc;
   logic         keep_local;
   logic [1:0]   gpio_count;
   logic         rate_changed;
   logic [7:0]   rdata;

   modport regs (
      input  wr_en, wr_local, addr, wdata, strap_rate, fc_valid, fc_gpio,
      output bcc, keep_local, gpio_count, rate_changed, rdata
   );
   modport hub (
      output wr_en, wr_local, addr, wdata, strap_rate, fc_valid, fc_gpio,
      input  bcc, keep_local, gpio_count, rate_changed, rdata
   );
endinterface : rpbc_port_if
`default_nettype wire

// file: rtl/rpbc_port_regs.sv
`include "rpbc_defines.svh"
`default_nettype none
module rpbc_port_regs
   import rpbc_pkg::*;
(
   input  wire logic  i_mclk,
   input  wire logic  i_rst,
   rpbc_port_if.regs  bus
);

   rpbc_port_state_type st;
   rpbc_port_state_type next_st;
   rpbc_bcc_type        wr_bcc;
   logic                bcc_wr;
   logic                dpc1_wr;

   assign bcc_wr  = bus.wr_en && (bus.addr == `RPBC_OFS_BCC);
   assign dpc1_wr = bus.wr_en && (bus.addr == `RPBC_OFS_DPC1);

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      wr_bcc               = rpbc_bcc_type'(bus.wdata);
      next_st              = st;
      next_st.rate_changed = 1'b0;
      if (!st.strap_done) begin
         next_st.bcc.rate   = bus.strap_rate; // RULE8
         next_st.strap_done = 1'b1;
      end else if (bcc_wr) begin
         next_st.bcc.pass_all   = wr_bcc.pass_all;   // RULE2
         next_st.bcc.pass_match = wr_bcc.pass_match; // RULE3
         next_st.bcc.auto_ack   = wr_bcc.auto_ack;   // RULE4
         next_st.bcc.crc_en     = wr_bcc.crc_en;     // RULE7
         next_st.bcc.rate       = wr_bcc.rate;       // RULE8
         next_st.rate_changed   = (wr_bcc.rate != st.bcc.rate); // RULE9
         if (bus.wr_local) begin
            next_st.bcc.force_on = wr_bcc.force_on;  // RULE6
         end
      end
      if (dpc1_wr) begin
         next_st.keep_local = bus.wdata[`RPBC_BIT_KEEP_LOCAL]; // RULE12
         if (bus.wdata[`RPBC_BIT_KEEP_LOCAL]) begin
            next_st.gpio_count = bus.wdata[1:0]; // RULE14
         end
      end else if (bus.fc_valid && !st.keep_local) begin
         next_st.gpio_count = bus.fc_gpio; // RULE12 RULE14
      end
   end

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         st            <= '0;
         st.bcc        <= rpbc_bcc_type'(`RPBC_BCC_RST);
      end else begin
         st <= next_st;
      end
   end

   // ----------------------------------------------------------------
   // Readback
   // ----------------------------------------------------------------
   always_comb begin
      case (bus.addr)
         `RPBC_OFS_BCC:  bus.rdata = st.bcc;
         `RPBC_OFS_DPC1: bus.rdata = {st.keep_local, 5'h00, st.gpio_count}; // RULE15
         default:        bus.rdata = 8'h00; // RULE15
      endcase
   end

   assign bus.bcc          = st.bcc;
   assign bus.keep_local   = st.keep_local;
   assign bus.gpio_count   = st.gpio_count;
   assign bus.rate_changed = st.rate_changed;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_rst);

   a_force_on_remote: assert property (st.strap_done && bcc_wr && !bus.wr_local |=> $stable(st.bcc.force_on)) // RULE6
      else $error("force-on bit changed by a remote write");
   a_bcc_write_store: assert property (st.strap_done && bcc_wr |=>
         st.bcc.pass_all == $past(bus.wdata[7]) && st.bcc.auto_ack == $past(bus.wdata[5])) // RULE2
      else $error("control bits not stored on write");
   a_crc_write_store: assert property (st.strap_done && bcc_wr |=> st.bcc.crc_en == $past(bus.wdata[3])) // RULE7
      else $error("crc enable not stored on write");
   a_rate_from_strap: assert property ($rose(st.strap_done) |-> st.bcc.rate == $past(bus.strap_rate)) // RULE8
      else $error("rate not loaded from strap");
   a_fc_gpio_load: assert property (bus.fc_valid && !st.keep_local && !dpc1_wr |=>
         st.gpio_count == $past(bus.fc_gpio)) // RULE12
      else $error("forward gpio count not loaded from remote");
   a_gpio_held: assert property (st.keep_local && !dpc1_wr |=> $stable(st.gpio_count)) // RULE14
      else $error("gpio count changed while locally held");
   a_rsvd_zero: assert property (bus.addr == `RPBC_OFS_DPC1 |-> bus.rdata[6:2] == 5'h00) // RULE15
      else $error("reserved bits read nonzero");

endmodule : rpbc_port_regs
`default_nettype wire

// file: rtl/rpbc_top.sv
//
// Contract
// RULE1: Register accesses go to the port picked by port select; each port keeps own copy.
// RULE2: Pass-all bit set forwards every local I2C transaction to the remote serializer.
// RULE3: Decode-match bit set forwards a transaction only when the port decoder matches.
// RULE4: Acknowledge-all bit set makes the hub acknowledge every write itself.
// RULE5: Force-on bit (reset 1) runs back channel; at 0 it needs a pass bit.
// RULE6: Force-on bit is writable only from the local I2C master, never remotely.
// RULE7: CRC generator enable (reset 1) appends CRC to back-channel traffic.
// RULE8: Rate field: 000 is 2.5 Mbps, 010 is 10 Mbps; reset value from strap.
// RULE9: After a rate change the back channel may err briefly; this is tolerated.
// RULE10: Host should enable auto-acknowledge before changing rate over the remote channel.
// RULE11: Host must not pick 20 or 100 Mbps with a 100 MHz reference.
// RULE12: Keep-local bit blocks forward-channel loading of datapath settings; clear allows it.
// RULE13: Forward GPIO count: 00 none, 01 one, 10 two, 11 four.
// RULE14: GPIO count loads from remote; local write sticks only with keep-local set.
// RULE15: Reserved bits read zero and writes to them do nothing.
//
`include "rpbc_defines.svh"
`default_nettype none
module rpbc_top
   import rpbc_pkg::*;
(
   input  wire logic        i_mclk,
   input  wire logic        i_rst,
   input  wire logic [1:0]  i_port_sel,
   input  wire logic        i_reg_wr,
   input  wire logic        i_reg_rd,
   input  wire logic        i_reg_local,
   input  wire logic [7:0]  i_reg_addr,
   input  wire logic [7:0]  i_reg_wdata,
   input  wire logic [2:0]  i_strap_bc_rate,
   input  wire logic [3:0]  i_fc_cfg_valid,
   input  wire logic [7:0]  i_fc_gpio_count,
   input  wire logic        i_txn_valid,
   input  wire logic [3:0]  i_txn_addr_match,
   output logic      [7:0]  o_reg_rdata,
   output logic      [3:0]  o_forward,
   output logic      [3:0]  o_auto_ack_all,
   output logic      [3:0]  o_bc_enable,
   output logic      [3:0]  o_crc_gen_en,
   output logic      [11:0] o_bc_rate_sel,
   output logic      [3:0]  o_rate_unsettled,
   output logic      [15:0] o_fwd_gpio_en,
   output logic      [3:0]  o_keep_local
);

   localparam int NP = `RPBC_NUM_PORTS;

   rpbc_top_state_type st;
   rpbc_top_state_type next_st;
   rpbc_bcc_type       port_bcc   [NP];
   logic [7:0]         port_rdata [NP];
   logic [1:0]         port_gpio  [NP];
   logic               port_keep  [NP];
   logic               port_chg   [NP];

   // ----------------------------------------------------------------
   // Per-port register copies
   // ----------------------------------------------------------------
   rpbc_port_if pif [NP] ();

   for (genvar g = 0; g < NP; g++) begin : g_port
      assign pif[g].wr_en      = i_reg_wr && (i_port_sel == 2'(g)); // RULE1
      assign pif[g].wr_local   = i_reg_local;
      assign pif[g].addr       = i_reg_addr;
      assign pif[g].wdata      = i_reg_wdata;
      assign pif[g].strap_rate = i_strap_bc_rate;
      assign pif[g].fc_valid   = i_fc_cfg_valid[g];
      assign pif[g].fc_gpio    = i_fc_gpio_count[2*g +: 2];
      assign port_bcc[g]       = pif[g].bcc;
      assign port_rdata[g]     = pif[g].rdata;
      assign port_gpio[g]      = pif[g].gpio_count;
      assign port_keep[g]      = pif[g].keep_local;
      assign port_chg[g]       = pif[g].rate_changed;

      rpbc_port_regs u_regs (
         .i_mclk (i_mclk),
         .i_rst  (i_rst),
         .bus    (pif[g].regs)
      );
   end

   // ----------------------------------------------------------------
   // Control-channel decisions and readback
   // ----------------------------------------------------------------
   always_comb begin
      next_st = st;
      if (i_reg_rd) begin
         next_st.rdata = port_rdata[i_port_sel]; // RULE1
      end
      for (int p = 0; p < NP; p++) begin
         next_st.forward[p]     = i_txn_valid && (port_bcc[p].pass_all ||               // RULE2
                                  (port_bcc[p].pass_match && i_txn_addr_match[p]));     // RULE3
         next_st.auto_ack[p]    = port_bcc[p].auto_ack;  // RULE4
         next_st.bc_enable[p]   = rpbc_bc_on(port_bcc[p]); // RULE5
         next_st.crc_en[p]      = port_bcc[p].crc_en;    // RULE7
         next_st.rate[3*p +: 3] = port_bcc[p].rate;      // RULE8
         next_st.unsettled[p]   = port_chg[p];           // RULE9
         next_st.gpio_en[4*p +: 4] = rpbc_gpio_mask(port_gpio[p]); // RULE13
         next_st.keep_local[p]  = port_keep[p];          // RULE12
      end
   end

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         st        <= '0;
         st.crc_en <= 4'hF;
         st.bc_enable <= 4'hF;
      end else begin
         st <= next_st;
      end
   end

   assign o_reg_rdata      = st.rdata;
   assign o_forward        = st.forward;
   assign o_auto_ack_all   = st.auto_ack;
   assign o_bc_enable      = st.bc_enable;
   assign o_crc_gen_en     = st.crc_en;
   assign o_bc_rate_sel    = st.rate;
   assign o_rate_unsettled = st.unsettled;
   assign o_fwd_gpio_en    = st.gpio_en;
   assign o_keep_local     = st.keep_local;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_rst);

   a_read_route: assert property (i_reg_rd && i_port_sel == 2'h2 |=> o_reg_rdata == $past(port_rdata[2])) // RULE1
      else $error("read not routed to selected port");
   a_write_isolate: assert property (i_reg_wr && i_port_sel != 2'h0 ##1 !i_reg_wr ##1 i_reg_rd && i_port_sel == 2'h0
         |=> o_reg_rdata == $past(port_rdata[0], 1)) // RULE1
      else $error("port 0 copy disturbed");
   a_forward_all: assert property (i_txn_valid && port_bcc[1].pass_all |=> o_forward[1]) // RULE2
      else $error("pass-all transaction not forwarded");
   a_forward_match: assert property (i_txn_valid && !port_bcc[0].pass_all && !i_txn_addr_match[0] |=> !o_forward[0]) // RULE3
      else $error("unmatched transaction forwarded");
   a_auto_ack_out: assert property (port_bcc[3].auto_ack |=> o_auto_ack_all[3]) // RULE4
      else $error("auto acknowledge not driven");
   a_bc_enable_gate: assert property (!port_bcc[0].force_on && !port_bcc[0].pass_all && !port_bcc[0].pass_match
         |=> !o_bc_enable[0]) // RULE5
      else $error("back channel on without cause");
   a_bc_force_on: assert property (port_bcc[2].force_on |=> o_bc_enable[2]) // RULE5
      else $error("forced back channel not running");
   a_crc_out: assert property (o_crc_gen_en[1] == $past(port_bcc[1].crc_en)) // RULE7
      else $error("crc enable output mismatch");
   a_gpio_decode: assert property (port_gpio[0] == 2'h2 |=> o_fwd_gpio_en[3:0] == 4'h3) // RULE13
      else $error("gpio count decode wrong");
   a_unsettled_pulse: assert property (port_chg[0] |=> o_rate_unsettled[0] ##1 (!o_rate_unsettled[0] || $past(port_chg[0]))) // RULE9
      else $error("rate change flag not a pulse");

   // ----------------------------------------------------------------
   // Output tracking checks
   // ----------------------------------------------------------------
   a_read_hold: assert property (!i_reg_rd |=> $stable(o_reg_rdata)) // RULE1
      else $error("read data changed without a read");

   a_read_port_three: assert property (i_reg_rd && i_port_sel == 2'h3 |=> o_reg_rdata == $past(port_rdata[3])) // RULE1
      else $error("read not routed to port 3");

   a_forward_pulse: assert property (!i_txn_valid |=> o_forward == 4'h0) // RULE2
      else $error("forward decision without a transaction");

   a_forward_hit: assert property (i_txn_valid && port_bcc[2].pass_match && i_txn_addr_match[2] |=> o_forward[2]) // RULE3
      else $error("matched transaction not forwarded");

   a_forward_no_pass: assert property (i_txn_valid && !port_bcc[3].pass_all && !port_bcc[3].pass_match
         |=> !o_forward[3]) // RULE3
      else $error("transaction forwarded with pass-through off");

   a_auto_ack_clear: assert property (!port_bcc[1].auto_ack |=> !o_auto_ack_all[1]) // RULE4
      else $error("auto acknowledge driven while off");

   a_auto_ack_zero: assert property (port_bcc[0].auto_ack |=> o_auto_ack_all[0]) // RULE4
      else $error("auto acknowledge port 0 not driven");

   a_bc_pass_on: assert property (port_bcc[1].pass_all || port_bcc[1].pass_match |=> o_bc_enable[1]) // RULE5
      else $error("back channel off despite pass-through");

   a_bc_off_three: assert property (!port_bcc[3].force_on && !port_bcc[3].pass_all && !port_bcc[3].pass_match
         |=> !o_bc_enable[3]) // RULE5
      else $error("back channel port 3 on without cause");

   a_crc_off: assert property (!port_bcc[0].crc_en |=> !o_crc_gen_en[0]) // RULE7
      else $error("crc generator on while disabled");

   a_crc_on_two: assert property (port_bcc[2].crc_en |=> o_crc_gen_en[2]) // RULE7
      else $error("crc generator port 2 not enabled");

   a_rate_track: assert property (o_bc_rate_sel[5:3] == $past(port_bcc[1].rate)) // RULE8
      else $error("rate output port 1 mismatch");

   a_rate_track_three: assert property (o_bc_rate_sel[11:9] == $past(port_bcc[3].rate)) // RULE8
      else $error("rate output port 3 mismatch");

   a_rate_idle: assert property (!port_chg[2] |=> !o_rate_unsettled[2]) // RULE9
      else $error("rate change flag without a change");

   a_rate_pulse_three: assert property (port_chg[3] |=> o_rate_unsettled[3]) // RULE9
      else $error("rate change flag port 3 missing");

   a_keep_track: assert property (port_keep[3] |=> o_keep_local[3]) // RULE12
      else $error("keep-local output not set");

   a_keep_clear: assert property (!port_keep[0] |=> !o_keep_local[0]) // RULE12
      else $error("keep-local output set while clear");

   a_gpio_none: assert property (port_gpio[1] == 2'h0 |=> o_fwd_gpio_en[7:4] == 4'h0) // RULE13
      else $error("gpio none decode wrong");

   a_gpio_one: assert property (port_gpio[0] == 2'h1 |=> o_fwd_gpio_en[3:0] == 4'h1) // RULE13
      else $error("gpio one decode wrong");

   a_gpio_four: assert property (port_gpio[0] == 2'h3 |=> o_fwd_gpio_en[3:0] == 4'hF) // RULE13
      else $error("gpio four decode wrong");

   a_gpio_two_hi: assert property (port_gpio[2] == 2'h2 |=> o_fwd_gpio_en[11:8] == 4'h3) // RULE13
      else $error("gpio two decode port 2 wrong");

endmodule : rpbc_top
`default_nettype wire

// file: tb/rpbc_host_model.sv
`default_nettype none
module rpbc_host_model (
   input  wire logic       i_mclk,
   input  wire logic [7:0] i_rdata,
   output logic      [1:0] o_port_sel,
   output logic            o_wr,
   output logic            o_rd,
   output logic            o_local,
   output logic      [7:0] o_addr,
   output logic      [7:0] o_wdata
);
   timeunit 1ns;
   timeprecision 100ps;

   initial begin
      o_port_sel = 2'h0;
      o_wr = 1'h0;
      o_rd = 1'h0;
      o_local = 1'h1;
      o_addr = 8'h00;
      o_wdata = 8'h00;
   end

   // Idle bus shows inverted address and data leftovers; port select and local flag keep their last values
   task automatic release_bus();
      o_wr = 1'h0;
      o_rd = 1'h0;
      o_addr = ~o_addr;
      o_wdata = ~o_wdata;
   endtask : release_bus

   task automatic wr(input logic [1:0] p, input logic [7:0] a, input logic [7:0] d, input logic loc);
      @(posedge i_mclk);
      #1;
      o_port_sel = p;
      o_addr = a;
      o_wdata = d;
      o_local = loc;
      o_wr = 1'h1;
      @(posedge i_mclk);
      #1;
      release_bus();
   endtask : wr

   task automatic rd(input logic [1:0] p, input logic [7:0] a, output logic [7:0] d);
      @(posedge i_mclk);
      #1;
      o_port_sel = p;
      o_addr = a;
      o_rd = 1'h1;
      @(posedge i_mclk);
      #1;
      d = i_rdata;
      release_bus();
   endtask : rd

   // Remote rate change: auto-ack first, only the two legal codes
   task automatic set_rate(input logic [1:0] p, input logic [2:0] code);
      wr(p, 8'h58, 8'h38, 1'h1);
      if (code == 3'h0 || code == 3'h2) begin
         wr(p, 8'h58, {5'h07, code}, 1'h0);
      end
   endtask : set_rate
endmodule : rpbc_host_model
`default_nettype wire

// file: tb/tb_rpbc_top.sv
`default_nettype none
module tb_rpbc_top;
   import rpbc_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;

   logic        i_mclk, i_rst, i_reg_wr, i_reg_rd, i_reg_local, i_txn_valid;
   logic [1:0]  i_port_sel;
   logic [7:0]  i_reg_addr, i_reg_wdata, i_fc_gpio_count, o_reg_rdata;
   logic [2:0]  i_strap_bc_rate;
   logic [3:0]  i_fc_cfg_valid, i_txn_addr_match, o_forward, o_auto_ack_all;
   logic [3:0]  o_bc_enable, o_crc_gen_en, o_rate_unsettled, o_keep_local;
   logic [11:0] o_bc_rate_sel;
   logic [15:0] o_fwd_gpio_en;
   logic [3:0]  gmask [4] = '{4'h0, 4'h1, 4'h3, 4'hF};
   int          err_total = 0;
   int          n_checks = 0;

   rpbc_top uut (.i_mclk(i_mclk), .i_rst(i_rst), .i_port_sel(i_port_sel), .i_reg_wr(i_reg_wr),
      .i_reg_rd(i_reg_rd), .i_reg_local(i_reg_local), .i_reg_addr(i_reg_addr),
      .i_reg_wdata(i_reg_wdata), .i_strap_bc_rate(i_strap_bc_rate), .i_fc_cfg_valid(i_fc_cfg_valid),
      .i_fc_gpio_count(i_fc_gpio_count), .i_txn_valid(i_txn_valid),
      .i_txn_addr_match(i_txn_addr_match), .o_reg_rdata(o_reg_rdata), .o_forward(o_forward),
      .o_auto_ack_all(o_auto_ack_all), .o_bc_enable(o_bc_enable), .o_crc_gen_en(o_crc_gen_en),
      .o_bc_rate_sel(o_bc_rate_sel), .o_rate_unsettled(o_rate_unsettled),
      .o_fwd_gpio_en(o_fwd_gpio_en), .o_keep_local(o_keep_local));

   rpbc_host_model host (.i_mclk(i_mclk), .i_rdata(o_reg_rdata), .o_port_sel(i_port_sel),
      .o_wr(i_reg_wr), .o_rd(i_reg_rd), .o_local(i_reg_local), .o_addr(i_reg_addr),
      .o_wdata(i_reg_wdata));

   initial begin
      i_mclk = 1'h0;
      forever #5 i_mclk = ~i_mclk;
   end

   task automatic conclude();
      if (err_total == 0 && n_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : conclude

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("Error %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic rd_chk(input logic [1:0] p, input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      host.rd(p, a, d);
      chk({8'h00, d}, {8'h00, exp});
   endtask : rd_chk

   task automatic settle();
      @(posedge i_mclk);
      #1;
   endtask : settle

   task automatic wrs(input logic [1:0] p, input logic [7:0] a, input logic [7:0] d, input logic loc);
      host.wr(p, a, d, loc);
      settle();
   endtask : wrs

   task automatic txn(input logic [3:0] match, input logic [3:0] exp);
      settle();
      i_txn_valid = 1'h1;
      i_txn_addr_match = match;
      settle();
      i_txn_valid = 1'h0;
      i_txn_addr_match = ~match;
      chk({12'h000, o_forward}, {12'h000, exp});
   endtask : txn

   task automatic fc(input logic [1:0] c);
      settle();
      i_fc_cfg_valid = 4'h1;
      i_fc_gpio_count = {6'h3F, c};
      settle();
      i_fc_cfg_valid = 4'h0;
      i_fc_gpio_count = ~i_fc_gpio_count;
      settle();
   endtask : fc

   initial begin
      #50000;
      err_total++;
      conclude();
   end

   initial begin
      i_rst = 1'h1;
      i_strap_bc_rate = 3'h2;
      i_fc_cfg_valid = 4'h0;
      i_fc_gpio_count = 8'h00;
      i_txn_valid = 1'h0;
      i_txn_addr_match = 4'h0;
      repeat (12) @(posedge i_mclk);
      #1;
      i_rst = 1'h0;
      repeat (3) settle();
      chk({12'h000, o_bc_enable}, 16'h000F);
      chk({12'h000, o_crc_gen_en}, 16'h000F);
      chk({4'h0, o_bc_rate_sel}, 16'h0492);
      for (int p = 0; p < 4; p++) begin
         rd_chk(p[1:0], 8'h58, 8'h1A);
         rd_chk(p[1:0], 8'h59, 8'h00);
      end
      // Per-port copies and local writes
      wrs(2'h1, 8'h58, 8'h28, 1'h1);
      rd_chk(2'h1, 8'h58, 8'h28);
      rd_chk(2'h0, 8'h58, 8'h1A);
      chk({12'h000, o_auto_ack_all}, 16'h0002);
      chk({12'h000, o_bc_enable}, 16'h000D);
      chk({4'h0, o_bc_rate_sel}, 16'h0482);
      // Remote writes cannot touch the force-on bit
      wrs(2'h1, 8'h58, 8'h10, 1'h0);
      rd_chk(2'h1, 8'h58, 8'h00);
      chk({12'h000, o_crc_gen_en}, 16'h000D);
      wrs(2'h0, 8'h58, 8'h08, 1'h0);
      rd_chk(2'h0, 8'h58, 8'h18);
      // Forwarding decisions
      wrs(2'h1, 8'h58, 8'h80, 1'h0);
      wrs(2'h2, 8'h58, 8'h40, 1'h1);
      chk({12'h000, o_bc_enable}, 16'h000F);
      txn(4'h0, 4'h2);
      txn(4'hF, 4'h6);
      txn(4'h1, 4'h2);
      wrs(2'h2, 8'h58, 8'h00, 1'h1);
      chk({12'h000, o_bc_enable}, 16'h000B);
      txn(4'h4, 4'h2);
      // Rate codes
      for (int c = 0; c < 4; c += 2) begin
         host.set_rate(2'h3, c[2:0]);
         settle();
         chk({12'h000, o_rate_unsettled}, (c == 2) ? 16'h0008 : 16'h0000);
         chk({13'h0000, o_bc_rate_sel[11:9]}, c[15:0]);
         rd_chk(2'h3, 8'h58, 8'h38 | c[7:0]);
      end
      // GPIO count from the forward channel and local override
      for (int c = 0; c < 4; c++) begin
         fc(c[1:0]);
         chk(o_fwd_gpio_en, {12'h000, gmask[c]});
      end
      wrs(2'h0, 8'h59, 8'h81, 1'h1);
      rd_chk(2'h0, 8'h59, 8'h81);
      chk({12'h000, o_keep_local}, 16'h0001);
      fc(2'h3);
      chk(o_fwd_gpio_en, 16'h0001);
      wrs(2'h0, 8'h59, 8'hFE, 1'h1);
      rd_chk(2'h0, 8'h59, 8'h82);
      wrs(2'h0, 8'h59, 8'h03, 1'h1);
      rd_chk(2'h0, 8'h59, 8'h02);
      fc(2'h3);
      chk(o_fwd_gpio_en, 16'h000F);
      wrs(2'h0, 8'h5A, 8'hFF, 1'h1);
      rd_chk(2'h0, 8'h5A, 8'h00);
      rd_chk(2'h0, 8'h5B, 8'h00);
      conclude();
   end
endmodule : tb_rpbc_top
`default_nettype wire
